/* File: common/cspm_pkg.sv */
// Package for the processing-state and power-mode controller.
// Assumes a single 250 MHz system clock and plain-port control.
package cspm_pkg;
   localparam int CSPM_CLK_MHZ = 250;
   localparam int CSPM_OSC_STAB_US = 100;
   localparam int CSPM_OSC_STAB_CYC = CSPM_OSC_STAB_US * CSPM_CLK_MHZ;
   localparam logic [31:0] CSPM_VEC_POR_PC = 32'h0000_0000;
   localparam logic [31:0] CSPM_VEC_POR_SP = 32'h0000_0004;
   localparam logic [31:0] CSPM_VEC_MAN_PC = 32'h0000_0008;
   localparam logic [31:0] CSPM_VEC_MAN_SP = 32'h0000_000C;
   localparam logic [31:0] CSPM_VBR_RESET = 32'h0000_0000;
   localparam logic [3:0] CSPM_MASK_RESET = 4'hF;
   localparam logic [2:0] CSPM_MODE_BUS8 = 3'h0;
   localparam logic [2:0] CSPM_MODE_BUS16 = 3'h1;
   localparam logic [2:0] CSPM_MODE_ROM = 3'h2;
   localparam logic [2:0] CSPM_MODE_PROM = 3'h7;
   localparam logic [1:0] CSPM_WID_BUS8 = 2'h0;
   localparam logic [1:0] CSPM_WID_BUS16 = 2'h1;
   localparam logic [1:0] CSPM_WID_ROM = 2'h2;
   localparam logic [1:0] CSPM_WID_NONE = 2'h3;
   typedef enum logic [2:0] {
      CSPM_ST_RESET, CSPM_ST_EXCEPT, CSPM_ST_BUSREL, CSPM_ST_EXEC, CSPM_ST_POWERDN
   } cspm_state_t;
   typedef enum logic [2:0] {
      CSPM_EX_IDLE, CSPM_EX_PUSH_SR, CSPM_EX_PUSH_PC, CSPM_EX_FETCH_PC, CSPM_EX_FETCH_SP,
      CSPM_EX_BRANCH
   } cspm_ex_t;
endpackage : cspm_pkg

/* File: hw/cspm_ctrl.sv */
// Processing-state and power-mode controller.
// Assumes chip_clear_n doubles as the synchronous reset; NMI and mode pins are synchronised here.
// Function
// - Exactly one of reset, exception, bus release, execution, power-down states.
// - Low chip clear means reset; NMI high selects power-on, low manual.
// - Power-on reset initialises all core state and peripheral registers.
// - Manual reset spares bus and pin controllers; refresh keeps running.
// - Reset exception fetches start PC and SP, then begins execution.
// - Interrupt pushes PC and status word, fetches handler, then resumes.
// - Bus release state grants the bus to the requester.
// - Sleep instruction with standby select clear enters sleep mode.
// - Sleep halts core, keeps registers and RAM; clock, peripherals run.
// - Sleep exits on interrupt, DMA address error or reset via exception.
// - Sleep with standby select set halts oscillator, core and peripherals.
// - Standby exits only on NMI or reset.
// - NMI wake waits oscillator stabilisation before exception processing.
// - Mode pins decode to 8-bit, 16-bit, on-chip ROM or PROM mode.
// - Vectors at 0x0/0x4 for power-on, 0x8/0xC for manual reset.
// - Reset clears vector base and sets interrupt mask to all ones.
// - Accepted interrupt level goes into mask; other exceptions leave it.
`timescale 1ns/10ps
module cspm_ctrl
   import cspm_pkg::*;
#(
   parameter int OSC_STAB_CYC = CSPM_OSC_STAB_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_nmi,
   input wire logic [2:0] i_boot_mode_pins,
   input wire logic i_standby_select_bit,
   input wire logic i_sleep_exec,
   input wire logic i_irq_req,
   input wire logic [3:0] i_irq_level,
   input wire logic i_other_exc,
   input wire logic i_dma_addr_err,
   input wire logic i_bus_req,
   input wire logic i_vec_ack,
   input wire logic [31:0] i_vec_data,
   input wire logic [31:0] i_irq_vec_addr,
   output logic [2:0] o_state,
   output logic o_por_flag,
   output logic o_periph_rst,
   output logic o_bsc_pfc_rst,
   output logic o_core_halt,
   output logic o_clk_stop,
   output logic o_periph_halt,
   output logic o_bus_grant,
   output logic o_vec_rd,
   output logic o_stack_wr,
   output logic [31:0] o_vec_addr,
   output logic [31:0] o_pc,
   output logic [31:0] o_sp,
   output logic [31:0] o_vector_base_reg,
   output logic [3:0] o_int_mask_field,
   output logic o_exec_start,
   output logic [1:0] o_area0_mode,
   output logic o_prom_mode,
   output logic o_mode_bad
);
   ////////////////////////////////////////////////////////////////////////////
   logic nmi_s;
   logic [2:0] mode_s;
   cspm_sync #(.WIDTH(4)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(1'b1),
      .i_async({i_nmi, i_boot_mode_pins}),
      .o_sync({nmi_s, mode_s})
   );

   function automatic logic [1:0] area0_of(input logic [2:0] m);
      case (m)
         CSPM_MODE_BUS8: area0_of = CSPM_WID_BUS8;
         CSPM_MODE_BUS16: area0_of = CSPM_WID_BUS16;
         CSPM_MODE_ROM: area0_of = CSPM_WID_ROM;
         default: area0_of = CSPM_WID_NONE;
      endcase
   endfunction : area0_of

   ////////////////////////////////////////////////////////////////////////////
   cspm_state_t state_reg;
   cspm_ex_t ex_reg;
   logic ex_is_reset_reg;
   logic in_standby_reg;
   logic [31:0] stab_cnt_reg;
   logic [3:0] pend_level_reg;
   logic reset_seen_reg;
   logic wake_sleep;

   // Clock stop is modelled as gating, so this counter runs on the system clock
   assign wake_sleep = i_irq_req | i_dma_addr_err;

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         state_reg <= CSPM_ST_RESET;
         reset_seen_reg <= 1'b1;
         in_standby_reg <= 1'b0;
         stab_cnt_reg <= '0;
      end else begin
         reset_seen_reg <= 1'b0;
         case (state_reg)
            CSPM_ST_RESET: state_reg <= CSPM_ST_EXCEPT;
            CSPM_ST_EXCEPT: begin
               if (ex_reg == CSPM_EX_BRANCH) begin
                  state_reg <= CSPM_ST_EXEC;
               end
            end
            CSPM_ST_EXEC: begin
               if (i_bus_req) begin
                  state_reg <= CSPM_ST_BUSREL;
               end else if (i_irq_req || i_other_exc) begin
                  state_reg <= CSPM_ST_EXCEPT;
               end else if (i_sleep_exec) begin
                  state_reg <= CSPM_ST_POWERDN;
                  in_standby_reg <= i_standby_select_bit;
               end
            end
            CSPM_ST_BUSREL: begin
               if (!i_bus_req) begin
                  state_reg <= CSPM_ST_EXEC;
               end
            end
            CSPM_ST_POWERDN: begin
               if (!in_standby_reg) begin
                  if (wake_sleep) begin
                     state_reg <= CSPM_ST_EXCEPT;
                  end
               end else if (stab_cnt_reg != 32'h0) begin
                  if (stab_cnt_reg >= 32'(OSC_STAB_CYC)) begin
                     state_reg <= CSPM_ST_EXCEPT;
                     in_standby_reg <= 1'b0;
                     stab_cnt_reg <= '0;
                  end else begin
                     stab_cnt_reg <= stab_cnt_reg + 32'h1;
                  end
               end else if (nmi_s) begin
                  stab_cnt_reg <= 32'h1;
               end
            end
            default: state_reg <= CSPM_ST_RESET;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Exception sequencer: stack push for non-reset exceptions, vector reads for both
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         ex_reg <= CSPM_EX_IDLE;
         ex_is_reset_reg <= 1'b1;
         pend_level_reg <= '0;
      end else if (state_reg == CSPM_ST_RESET) begin
         ex_reg <= CSPM_EX_FETCH_PC;
         ex_is_reset_reg <= 1'b1;
      end else if (state_reg != CSPM_ST_EXCEPT) begin
         ex_reg <= CSPM_EX_PUSH_SR;
         ex_is_reset_reg <= 1'b0;
         pend_level_reg <= i_irq_req ? i_irq_level : 4'h0;
      end else begin
         case (ex_reg)
            CSPM_EX_PUSH_SR: ex_reg <= CSPM_EX_PUSH_PC;
            CSPM_EX_PUSH_PC: ex_reg <= CSPM_EX_FETCH_PC;
            CSPM_EX_FETCH_PC: begin
               if (i_vec_ack) begin
                  ex_reg <= ex_is_reset_reg ? CSPM_EX_FETCH_SP : CSPM_EX_BRANCH;
               end
            end
            CSPM_EX_FETCH_SP: begin
               if (i_vec_ack) begin
                  ex_reg <= CSPM_EX_BRANCH;
               end
            end
            CSPM_EX_BRANCH: ex_reg <= CSPM_EX_IDLE;
            default: ex_reg <= CSPM_EX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset kind is latched on the release edge, so NMI is never an async load
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_periph_rst <= 1'b1;
         o_bsc_pfc_rst <= 1'b0;
      end else begin
         if (reset_seen_reg) begin
            o_por_flag <= nmi_s;
            o_bsc_pfc_rst <= nmi_s;
         end else begin
            o_bsc_pfc_rst <= 1'b0;
         end
         o_periph_rst <= reset_seen_reg;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_pc <= '0;
         o_sp <= '0;
         o_vector_base_reg <= CSPM_VBR_RESET;
         o_int_mask_field <= CSPM_MASK_RESET;
         o_vec_rd <= 1'b0;
         o_stack_wr <= 1'b0;
         o_vec_addr <= '0;
         o_exec_start <= 1'b0;
      end else begin
         o_vec_rd <= (ex_reg == CSPM_EX_FETCH_PC || ex_reg == CSPM_EX_FETCH_SP)
                     && state_reg == CSPM_ST_EXCEPT && !i_vec_ack;
         o_stack_wr <= state_reg == CSPM_ST_EXCEPT
                       && (ex_reg == CSPM_EX_PUSH_SR || ex_reg == CSPM_EX_PUSH_PC);
         o_exec_start <= state_reg == CSPM_ST_EXCEPT && ex_reg == CSPM_EX_BRANCH;
         if (ex_reg == CSPM_EX_FETCH_PC) begin
            o_vec_addr <= !ex_is_reset_reg ? i_irq_vec_addr :
                          (o_por_flag ? CSPM_VEC_POR_PC : CSPM_VEC_MAN_PC);
         end else if (ex_reg == CSPM_EX_FETCH_SP) begin
            o_vec_addr <= o_por_flag ? CSPM_VEC_POR_SP : CSPM_VEC_MAN_SP;
         end
         if (state_reg == CSPM_ST_EXCEPT && i_vec_ack) begin
            if (ex_reg == CSPM_EX_FETCH_PC) begin
               o_pc <= i_vec_data;
            end else if (ex_reg == CSPM_EX_FETCH_SP) begin
               o_sp <= i_vec_data;
               o_vector_base_reg <= CSPM_VBR_RESET;
               o_int_mask_field <= CSPM_MASK_RESET;
            end
         end
         if (state_reg == CSPM_ST_EXCEPT && ex_reg == CSPM_EX_PUSH_SR
             && pend_level_reg != 4'h0) begin
            o_int_mask_field <= pend_level_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_state <= 3'h0;
         o_core_halt <= 1'b1;
         o_clk_stop <= 1'b0;
         o_periph_halt <= 1'b0;
         o_bus_grant <= 1'b0;
         o_area0_mode <= CSPM_WID_BUS8;
         o_prom_mode <= 1'b0;
         o_mode_bad <= 1'b0;
      end else begin
         o_state <= 3'(state_reg);
         o_core_halt <= state_reg == CSPM_ST_POWERDN;
         o_clk_stop <= state_reg == CSPM_ST_POWERDN && in_standby_reg
                       && stab_cnt_reg == 32'h0;
         o_periph_halt <= state_reg == CSPM_ST_POWERDN && in_standby_reg;
         o_bus_grant <= state_reg == CSPM_ST_BUSREL;
         o_area0_mode <= area0_of(mode_s);
         o_prom_mode <= mode_s == CSPM_MODE_PROM;
         o_mode_bad <= area0_of(mode_s) == CSPM_WID_NONE && mode_s != CSPM_MODE_PROM;
      end
   end
endmodule : cspm_ctrl

/* File: hw/cspm_sync.sv */
// Two-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous levels.
`timescale 1ns/10ps
module cspm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         meta_reg <= '0;
         o_sync <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule : cspm_sync

/* File: verification/cspm_ctrl_monitor.sv */
// Checker for the processing-state and power-mode controller.
// Assumes it is bound to cspm_ctrl and sees only its ports.
`timescale 1ns/10ps
module cspm_ctrl_monitor (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_nmi,
   input wire logic [2:0] i_boot_mode_pins,
   input wire logic i_bus_req,
   input wire logic i_vec_ack,
   input wire logic [2:0] o_state,
   input wire logic o_por_flag,
   input wire logic o_periph_rst,
   input wire logic o_core_halt,
   input wire logic o_clk_stop,
   input wire logic o_periph_halt,
   input wire logic o_bus_grant,
   input wire logic o_vec_rd,
   input wire logic [31:0] o_vec_addr,
   input wire logic [31:0] o_vector_base_reg,
   input wire logic [3:0] o_int_mask_field,
   input wire logic o_mode_bad
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   property p_legal; o_state <= 3'h4; endproperty
   a_legal: assert property (p_legal) else $error("illegal state");
   property p_grant; i_bus_req && o_state == 3'h3 |-> ##[1:3] o_bus_grant; endproperty
   a_grant: assert property (p_grant) else $error("bus not granted");
   property p_grant_st; o_bus_grant |-> ##[0:2] o_state == 3'h2; endproperty
   a_grant_st: assert property (p_grant_st) else $error("grant outside release");
   // Standby keeps peripherals halted through stabilisation, so only sleep is judged here
   property p_sleep; o_core_halt && !o_periph_halt |=> !o_periph_halt && !o_clk_stop;
   endproperty
   a_sleep: assert property (p_sleep) else $error("peripherals halted in sleep");
   property p_stby; o_clk_stop |-> o_core_halt && o_periph_halt; endproperty
   a_stby: assert property (p_stby) else $error("standby not fully halted");
   // Fetch must hold its address until answered, or the word lands in the wrong place
   property p_vec; o_vec_rd && !i_vec_ack |=> o_vec_rd && $stable(o_vec_addr); endproperty
   a_vec: assert property (p_vec) else $error("vector read dropped");
   property p_rvec; o_vec_rd && o_vec_addr < 32'h10 |-> o_vec_addr[3] == !o_por_flag; endproperty
   a_rvec: assert property (p_rvec) else $error("wrong reset vector");
   property p_rmask; o_vec_rd && i_vec_ack && o_vec_addr < 32'h10 && o_vec_addr[2]
      |=> o_int_mask_field == 4'hF && o_vector_base_reg == 32'h0;
   endproperty
   a_rmask: assert property (p_rmask) else $error("mask or base wrong");
   property p_bad; i_boot_mode_pins == 3'h3 [*5] |-> o_mode_bad; endproperty
   a_bad: assert property (p_bad) else $error("bad mode unflagged");
   property p_nowake; (o_clk_stop && !i_nmi) [*3] |=> o_clk_stop; endproperty
   a_nowake: assert property (p_nowake) else $error("standby left without wake");
   property p_prst; $rose(i_reset_n) |=> o_periph_rst ##1 !o_periph_rst; endproperty
   a_prst: assert property (p_prst) else $error("peripheral reset pulse wrong");
endmodule : cspm_ctrl_monitor

/* File: verification/cspm_ctrl_tb.sv */
// Self-checking bench for the processing-state and power-mode controller.
// Assumes the vector memory model; stabilisation count shortened to 8.
`timescale 1ns/10ps
module cspm_ctrl_tb;
   import cspm_pkg::*;
   localparam int OSC = 8;
   localparam logic [31:0] VB = 32'h1000_0000;
   logic i_clk_sys, i_reset_n, i_nmi, i_standby_select_bit, i_sleep_exec, i_irq_req;
   logic i_other_exc, i_dma_addr_err, i_bus_req, i_vec_ack;
   logic [2:0] i_boot_mode_pins, o_state;
   logic [3:0] i_irq_level, o_int_mask_field, wt;
   logic [31:0] i_vec_data, i_irq_vec_addr, o_vec_addr, o_pc, o_sp, o_vector_base_reg;
   logic o_por_flag, o_periph_rst, o_bsc_pfc_rst, o_core_halt, o_clk_stop, o_periph_halt;
   logic o_bus_grant, o_vec_rd, o_stack_wr, o_exec_start, o_prom_mode, o_mode_bad;
   logic [1:0] o_area0_mode;
   int n_mismatch = 0, n_compared = 0, cyc = 0, n_stk = 0, n_bsc = 0, k, i;
   cspm_ctrl #(.OSC_STAB_CYC(OSC)) dut (.i_clk_sys, .i_reset_n, .i_nmi, .i_boot_mode_pins,
      .i_standby_select_bit, .i_sleep_exec, .i_irq_req, .i_irq_level, .i_other_exc,
      .i_dma_addr_err, .i_bus_req, .i_vec_ack, .i_vec_data, .i_irq_vec_addr, .o_state,
      .o_por_flag, .o_periph_rst, .o_bsc_pfc_rst, .o_core_halt, .o_clk_stop, .o_periph_halt,
      .o_bus_grant, .o_vec_rd, .o_stack_wr, .o_vec_addr, .o_pc, .o_sp, .o_vector_base_reg,
      .o_int_mask_field, .o_exec_start, .o_area0_mode, .o_prom_mode, .o_mode_bad);
   cspm_vec_mem u_mem (.i_clk_sys, .i_wait(wt), .i_vec_rd(o_vec_rd), .i_vec_addr(o_vec_addr),
      .o_vec_ack(i_vec_ack), .o_vec_data(i_vec_data));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk_sys = 0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      n_stk += o_stack_wr;
      n_bsc += o_bsc_pfc_rst;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : step
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_exec();
      for (k = 0; k < 400 && o_exec_start !== 1'b1; k++) step(1);
      chk(k < 400, 1);
      step(2);
      chk(o_state, 3'h3);
   endtask : wait_exec
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic go_sleep(input logic sb);
      i_standby_select_bit <= sb;
      i_sleep_exec <= 1'b1;
      step(1);
      i_sleep_exec <= 1'b0;
      step(4);
      chk({o_core_halt, o_clk_stop, o_periph_halt}, {1'b1, sb, sb});
   endtask : go_sleep
   initial begin
      {i_reset_n, i_standby_select_bit, i_sleep_exec, i_irq_req, i_irq_level} = 0;
      {i_other_exc, i_dma_addr_err, i_bus_req, wt} = 0;
      i_nmi = 1;
      i_boot_mode_pins = 3'h2;
      i_irq_vec_addr = 32'h100;
      step(4);
      i_reset_n <= 1'b1;
      wait_exec();
      chk(o_pc, VB);
      chk(o_sp, VB | 4);
      chk(o_vector_base_reg, 32'h0);
      chk(o_int_mask_field, 4'hF);
      chk({o_por_flag, n_bsc > 0}, 2'b11);
      i_nmi <= 1'b0;
      // Mode pins move only under reset, so they stand still while the chip runs
      for (i = 0; i < 8; i++) begin
         i_reset_n <= 1'b0;
         i_boot_mode_pins <= i[2:0];
         step(4);
         i_reset_n <= 1'b1;
         step(6);
         chk(o_area0_mode, i < 3 ? i[1:0] : CSPM_WID_NONE);
         chk({o_prom_mode, o_mode_bad}, {i == 7, i inside {[3:6]}});
      end
      // The modelled part carries PROM, so pattern 7 above is a legal choice
      i_reset_n <= 1'b0;
      i_boot_mode_pins <= 3'h2;
      step(4);
      i_reset_n <= 1'b1;
      wait_exec();
      wt <= 4'h3;
      i_bus_req <= 1'b1;
      step(5);
      chk({o_bus_grant, o_state}, {1'b1, 3'h2});
      i_bus_req <= 1'b0;
      step(5);
      chk(o_bus_grant, 0);
      n_stk <= 0;
      i_irq_level <= 4'h5;
      i_irq_req <= 1'b1;
      step(3);
      i_irq_req <= 1'b0;
      wait_exec();
      chk(o_int_mask_field, 4'h5);
      chk(o_pc, VB | 32'h100);
      chk(n_stk, 2);
      i_other_exc <= 1'b1;
      step(1);
      i_other_exc <= 1'b0;
      wait_exec();
      chk(o_int_mask_field, 4'h5);
      for (i = 0; i < 2; i++) begin
         go_sleep(1'b0);
         i_irq_req <= i[0];
         i_dma_addr_err <= !i[0];
         step(1);
         {i_irq_req, i_dma_addr_err} <= 2'b00;
         wait_exec();
      end
      go_sleep(1'b1);
      i_irq_req <= 1'b1;
      step(8);
      chk(o_state, 3'h4);
      i_irq_req <= 1'b0;
      i_nmi <= 1'b1;
      for (k = 0; k < 100 && o_state !== 3'h1; k++) step(1);
      chk(k >= OSC && k < 100, 1);
      wait_exec();
      i_nmi <= 1'b0;
      i_reset_n <= 1'b0;
      step(4);
      n_bsc <= 0;
      i_reset_n <= 1'b1;
      wait_exec();
      chk(o_pc, VB | 8);
      chk(o_sp, VB | 32'hC);
      chk(o_por_flag, 0);
      chk(n_bsc, 0);
      give_verdict();
   end
endmodule : cspm_ctrl_tb
bind cspm_ctrl cspm_ctrl_monitor u_mon (.i_clk_sys, .i_reset_n, .i_nmi, .i_boot_mode_pins,
   .i_bus_req, .i_vec_ack, .o_state, .o_por_flag, .o_periph_rst, .o_core_halt, .o_clk_stop,
   .o_periph_halt,
   .o_bus_grant, .o_vec_rd, .o_vec_addr, .o_vector_base_reg, .o_int_mask_field, .o_mode_bad);

/* File: verification/cspm_vec_mem.sv */
// Vector memory model on the far side of the vector fetch port.
// Assumes one clock; i_wait sets answer delay, word is base OR address.
`timescale 1ns/10ps
module cspm_vec_mem (
   input wire logic i_clk_sys,
   input wire logic [3:0] i_wait,
   input wire logic i_vec_rd,
   input wire logic [31:0] i_vec_addr,
   output logic o_vec_ack = 1'b0,
   output logic [31:0] o_vec_data = 32'h0
);
   logic [3:0] cnt_reg = 4'h0;
   logic done_reg = 1'b0;
   logic [31:0] addr_reg = 32'h0;
   ////////////////////////////////////////////////////////////////////////////////
   // Data toggles outside the ack cycle so a sample one cycle late never looks right
   always_ff @(posedge i_clk_sys) begin
      o_vec_ack <= 1'b0;
      o_vec_data <= ~o_vec_data;
      if (!i_vec_rd || i_vec_addr != addr_reg) begin
         cnt_reg <= 4'h0;
         done_reg <= 1'b0;
         addr_reg <= i_vec_addr;
      end else if (!done_reg && cnt_reg == i_wait) begin
         o_vec_ack <= 1'b1;
         o_vec_data <= 32'h1000_0000 | i_vec_addr;
         done_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule : cspm_vec_mem
